// ==== wid_map.vh ====
// constants for the wakeup and interrupt dispatch block
// assumes a 32-bit axi4-lite register port with byte addresses
`ifndef WID_MAP_VH
`define WID_MAP_VH

// register byte offsets
`define WID_WAKE_CTRL_OFS 8'h00
`define WID_INT_EN_OFS 8'h04
`define WID_INT_FLAG_OFS 8'h08
`define WID_WDOG_CTRL_OFS 8'h0c
`define WID_STATUS_OFS 8'h10

// field positions; bits 0-4 shared by enable and flag registers, then alt enable, watchdog and status bits
`define WID_TMR_BIT 0
`define WID_PIN_BIT 1
`define WID_CMP_BIT 2
`define WID_EXT_BIT 3
`define WID_PWM_BIT 4
`define WID_CMP_ALT_BIT 7
`define WID_WDOG_BIT 7
`define WID_GIE_BIT 0
`define WID_SLEEP_BIT 1

// reset values
`define WID_WAKE_CTRL_RST 2'h0
`define WID_INT_EN_RST 5'h00
`define WID_INT_FLAG_RST 5'h00
`define WID_WDOG_RST 1'h1
`define WID_PIN_IDLE 8'hff
`define WID_EXT_IDLE 1'h1

// vector addresses
`define WID_VEC_RESET 8'h00
`define WID_VEC_EXT 8'h03
`define WID_VEC_PIN 8'h06
`define WID_VEC_TMR 8'h09
`define WID_VEC_CMP 8'h0c
`define WID_VEC_PWM 8'h0f

// axi responses
`define WID_RESP_OKAY 2'h0
`define WID_RESP_SLVERR 2'h2

`endif

// ==== wid_src_model.sv ====
// event sources and core sequencer pulses facing the dispatch block
// assumes sys_clk_i shared with the design; pins idle high
module wid_src_model (
  input wire sys_clk_i,
  output logic [8:0] ev_o,
  output logic [7:0] pins_o,
  output logic ext_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    ev_o = 9'h0;
    pins_o = 8'hff;
    ext_o = 1'b1;
  end
  // pins move as levels; ext held low long enough to cross the synchroniser
  task fire(input int k);
    @(posedge sys_clk_i);
    if (k == 1) pins_o <= pins_o ^ (8'h01 << $urandom_range(7));
    else if (k == 3) ext_o <= 1'b0;
    else ev_o[k] <= 1'b1;
    @(posedge sys_clk_i);
    ev_o <= 9'h0;
    repeat (3) @(posedge sys_clk_i);
    ext_o <= 1'b1;
  endtask
endmodule // wid_src_model

// ==== wid_sync.v ====
// two-flop synchroniser for a group of pin levels
// assumes pins are asynchronous to sys_clk_i
module wid_sync #(
  parameter WIDTH = 9,
  parameter [WIDTH-1:0] IDLE = {WIDTH{1'b1}}
) (
  input wire sys_clk_i,
  input wire srst_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta;

  // idle level at reset so no false edge is seen after release
  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      meta <= IDLE;
      sync_o <= IDLE;
    end
    else
    begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule // wid_sync

// ==== wid_top.v ====
// wakeup and interrupt dispatch with axi4-lite register port
// assumes core sequencer and event sources on sys_clk_i; pins asynchronous
`include "wid_map.vh"

// Function
// - normal timer overflow sets flag, continues
// - timer overflow with interrupts on vectors 0x09
// - sleep pin change, both enables clear: nothing
// - sleep pin change, int only: flag, no wake
// - sleep pin change, wake only: wake, next
// - sleep pin change, both, gie off: wake, flag, next
// - sleep pin change, both, gie on: vector 0x06
// - normal pin change gated by its enable
// - external pin event flag, vector 0x03
// - pwm period match flag, vector 0x0f
// - sleep comparator, both enables clear: nothing
// - sleep comparator, int only: flag, no wake
// - sleep comparator, wake only: wake, next
// - sleep comparator, both, gie off: wake, flag, next
// - sleep comparator, both, gie on: vector 0x0c
// - normal comparator gated by enable, vector 0x0c
// - watchdog timeout resets to 0x00, wakes first
// - watchdog re-enabled after any wake
module wid_top #(
  parameter ADDR_W = 8,
  parameter PIN_W = 8
) (
  input wire sys_clk_i,
  input wire srst_i,
  input wire [ADDR_W-1:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [ADDR_W-1:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire global_int_on_instr_i,
  input wire global_int_off_instr_i,
  input wire sleep_instr_i,
  input wire timer_overflow_i,
  input wire period_match_i,
  input wire comparator_change_i,
  input wire watchdog_timeout_i,
  input wire [PIN_W-1:0] port6_pins_i,
  input wire ext_pin_i,
  output reg wake_o,
  output reg resume_next_o,
  output reg vector_req_o,
  output reg [7:0] vector_addr_o,
  output reg core_reset_o,
  output reg clock_run_o
);

  reg pin_change_wake_enable;
  reg comparator_wake_enable;
  reg timer_overflow_int_enable;
  reg pin_change_int_enable;
  reg comparator_int_enable;
  reg ext_pin_int_enable;
  reg period_match_int_enable;
  reg watchdog_enable;
  reg [4:0] pending;
  reg gie;
  reg sleeping;
  reg aw_got, w_got;
  reg [ADDR_W-1:0] aw_addr;
  reg [7:0] w_byte;
  reg w_lane0;
  reg [PIN_W-1:0] pin_prev;
  reg ext_prev;
  wire [PIN_W:0] pins_sync;
  wire [PIN_W-1:0] pin_now;
  wire ext_now;
  wire wr_en, wr_ok;
  reg pin_evt, ext_evt;
  reg [4:0] set_flag, clr_flag;
  reg vec_tmr, vec_pin, vec_cmp, vec_ext, vec_pwm;
  reg take_vec;
  reg [7:0] next_vector;
  reg wake_any, wdt_fire, next_sleeping;
  reg [7:0] rd_byte;

  function is_mapped;
    input [ADDR_W-1:0] a;
    begin
      is_mapped = (a == `WID_WAKE_CTRL_OFS) || (a == `WID_INT_EN_OFS) ||
        (a == `WID_INT_FLAG_OFS) || (a == `WID_WDOG_CTRL_OFS) || (a == `WID_STATUS_OFS);
    end
  endfunction

  wid_sync #(
    .WIDTH(PIN_W + 1),
    .IDLE({`WID_EXT_IDLE, `WID_PIN_IDLE})
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .async_i({ext_pin_i, port6_pins_i}),
    .sync_o(pins_sync)
  );

  assign pin_now = pins_sync[PIN_W-1:0];
  assign ext_now = pins_sync[PIN_W];
  assign wr_en = aw_got && w_got && !s_axi_bvalid_o;
  assign wr_ok = wr_en && is_mapped(aw_addr) && w_lane0;

  // event decode; sleep stops the timer, pwm and external paths
  always @*
  begin
    pin_evt = |(pin_now ^ pin_prev);
    ext_evt = ext_prev && !ext_now;
    wdt_fire = watchdog_timeout_i && watchdog_enable;
    set_flag = 5'h00;
    set_flag[`WID_TMR_BIT] = timer_overflow_i && !sleeping && timer_overflow_int_enable;
    set_flag[`WID_EXT_BIT] = ext_evt && !sleeping && ext_pin_int_enable;
    set_flag[`WID_PWM_BIT] = period_match_i && !sleeping && period_match_int_enable;
    set_flag[`WID_PIN_BIT] = pin_evt && pin_change_int_enable;
    set_flag[`WID_CMP_BIT] = comparator_change_i && comparator_int_enable;
    wake_any = sleeping && ((pin_evt && pin_change_wake_enable) ||
      (comparator_change_i && comparator_wake_enable));
    vec_tmr = set_flag[`WID_TMR_BIT] && gie;
    vec_ext = set_flag[`WID_EXT_BIT] && gie;
    vec_pwm = set_flag[`WID_PWM_BIT] && gie;
    vec_pin = set_flag[`WID_PIN_BIT] && gie && (!sleeping || pin_change_wake_enable);
    vec_cmp = set_flag[`WID_CMP_BIT] && gie && (!sleeping || comparator_wake_enable);
    take_vec = vec_tmr || vec_ext || vec_pwm || vec_pin || vec_cmp;
    // lowest vector address wins when events coincide
    if (vec_ext)
      next_vector = `WID_VEC_EXT;
    else if (vec_pin)
      next_vector = `WID_VEC_PIN;
    else if (vec_tmr)
      next_vector = `WID_VEC_TMR;
    else if (vec_cmp)
      next_vector = `WID_VEC_CMP;
    else
      next_vector = `WID_VEC_PWM;
    clr_flag = 5'h00;
    if (wr_ok && aw_addr == `WID_INT_FLAG_OFS)
      clr_flag = w_byte[4:0];
    next_sleeping = sleeping;
    if (wdt_fire || wake_any)
      next_sleeping = 1'b0;
    else if (sleep_instr_i)
      next_sleeping = 1'b1;
  end

  // core-facing dispatch
  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      sleeping <= 1'b0;
      gie <= 1'b0;
      pending <= `WID_INT_FLAG_RST;
      pin_prev <= `WID_PIN_IDLE;
      ext_prev <= `WID_EXT_IDLE;
      wake_o <= 1'b0;
      resume_next_o <= 1'b0;
      vector_req_o <= 1'b0;
      vector_addr_o <= `WID_VEC_RESET;
      core_reset_o <= 1'b0;
      clock_run_o <= 1'b1;
    end
    else
    begin
      pin_prev <= pin_now;
      ext_prev <= ext_now;
      sleeping <= next_sleeping;
      clock_run_o <= !next_sleeping;
      if (global_int_on_instr_i)
        gie <= 1'b1;
      else if (global_int_off_instr_i)
        gie <= 1'b0;
      // a set in the same cycle as a clear wins
      pending <= (pending & ~clr_flag) | set_flag;
      core_reset_o <= wdt_fire;
      wake_o <= wake_any || (wdt_fire && sleeping);
      vector_req_o <= !wdt_fire && take_vec && (!sleeping || wake_any);
      resume_next_o <= !wdt_fire && wake_any && !take_vec;
      if (wdt_fire)
        vector_addr_o <= `WID_VEC_RESET;
      else if (take_vec)
        vector_addr_o <= next_vector;
    end
  end

  // software registers
  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      {comparator_wake_enable, pin_change_wake_enable} <= `WID_WAKE_CTRL_RST;
      {period_match_int_enable, ext_pin_int_enable, comparator_int_enable,
        pin_change_int_enable, timer_overflow_int_enable} <= `WID_INT_EN_RST;
      watchdog_enable <= `WID_WDOG_RST;
    end
    else
    begin
      if (wr_ok && aw_addr == `WID_WAKE_CTRL_OFS)
      begin
        pin_change_wake_enable <= w_byte[`WID_PIN_BIT];
        comparator_wake_enable <= w_byte[`WID_CMP_BIT];
      end
      if (wr_ok && aw_addr == `WID_INT_EN_OFS)
      begin
        timer_overflow_int_enable <= w_byte[`WID_TMR_BIT];
        pin_change_int_enable <= w_byte[`WID_PIN_BIT];
        // two positions name the same comparator enable
        comparator_int_enable <= w_byte[`WID_CMP_BIT] | w_byte[`WID_CMP_ALT_BIT];
        ext_pin_int_enable <= w_byte[`WID_EXT_BIT];
        period_match_int_enable <= w_byte[`WID_PWM_BIT];
      end
      // wake re-arms the watchdog over any software write
      if ((sleeping && (wake_any || wdt_fire)))
        watchdog_enable <= 1'b1;
      else if (wr_ok && aw_addr == `WID_WDOG_CTRL_OFS)
        watchdog_enable <= w_byte[`WID_WDOG_BIT];
    end
  end

  // axi4-lite write channel
  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `WID_RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end
    else
    begin
      if (s_axi_awready_o && s_axi_awvalid_i)
      begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      else if (!aw_got && !s_axi_bvalid_o && !wr_en)
        s_axi_awready_o <= 1'b1;
      if (s_axi_wready_o && s_axi_wvalid_i)
      begin
        w_got <= 1'b1;
        w_byte <= s_axi_wdata_i[7:0];
        w_lane0 <= s_axi_wstrb_i[0];
        s_axi_wready_o <= 1'b0;
      end
      else if (!w_got && !s_axi_bvalid_o && !wr_en)
        s_axi_wready_o <= 1'b1;
      if (wr_en)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= is_mapped(aw_addr) ? `WID_RESP_OKAY : `WID_RESP_SLVERR;
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end

  // read data; upper bits always zero
  always @*
  begin
    rd_byte = 8'h00;
    case (s_axi_araddr_i)
      `WID_WAKE_CTRL_OFS:
      begin
        rd_byte[`WID_PIN_BIT] = pin_change_wake_enable;
        rd_byte[`WID_CMP_BIT] = comparator_wake_enable;
      end
      `WID_INT_EN_OFS:
      begin
        rd_byte[`WID_TMR_BIT] = timer_overflow_int_enable;
        rd_byte[`WID_PIN_BIT] = pin_change_int_enable;
        rd_byte[`WID_CMP_BIT] = comparator_int_enable;
        rd_byte[`WID_EXT_BIT] = ext_pin_int_enable;
        rd_byte[`WID_PWM_BIT] = period_match_int_enable;
        rd_byte[`WID_CMP_ALT_BIT] = comparator_int_enable;
      end
      `WID_INT_FLAG_OFS:
        rd_byte[4:0] = pending;
      `WID_WDOG_CTRL_OFS:
        rd_byte[`WID_WDOG_BIT] = watchdog_enable;
      `WID_STATUS_OFS:
      begin
        rd_byte[`WID_GIE_BIT] = gie;
        rd_byte[`WID_SLEEP_BIT] = sleeping;
      end
      default:
        rd_byte = 8'h00;
    endcase
  end

  // axi4-lite read channel, one outstanding read
  always @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `WID_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arready_o && s_axi_arvalid_i)
      begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= {24'h00_0000, rd_byte};
        s_axi_rresp_o <= is_mapped(s_axi_araddr_i) ? `WID_RESP_OKAY : `WID_RESP_SLVERR;
      end
      else if (s_axi_rvalid_o && s_axi_rready_i)
        s_axi_rvalid_o <= 1'b0;
      else if (!s_axi_rvalid_o)
        s_axi_arready_o <= 1'b1;
    end
  end

endmodule // wid_top

// ==== wid_top_props.sv ====
// assertions on the dispatch outputs of wid_top
// assumes a bind onto wid_top, a single clock domain
module wid_top_props (
  input wire sys_clk_i,
  input wire srst_i,
  input wire timer_overflow_i,
  input wire period_match_i,
  input wire comparator_change_i,
  input wire watchdog_timeout_i,
  input wire wake_o,
  input wire resume_next_o,
  input wire vector_req_o,
  input wire [7:0] vector_addr_o,
  input wire core_reset_o,
  input wire clock_run_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  a_tmr_vector: assert property (vector_req_o && vector_addr_o == 8'h09 |->
    $past(timer_overflow_i) || $past(timer_overflow_i, 2)) else $error("timer vector without overflow");
  a_pwm_vector: assert property (vector_req_o && vector_addr_o == 8'h0f |->
    $past(period_match_i) || $past(period_match_i, 2)) else $error("pwm vector without match");
  a_cmp_vector: assert property (vector_req_o && vector_addr_o == 8'h0c |->
    $past(comparator_change_i) || $past(comparator_change_i, 2)) else $error("cmp vector without change");
  a_wdog_first: assert property (core_reset_o |-> !vector_req_o && !resume_next_o)
    else $error("vector or resume beside watchdog reset");
  a_wdog_cause: assert property (core_reset_o |->
    $past(watchdog_timeout_i) || $past(watchdog_timeout_i, 2)) else $error("reset without timeout");
  a_wake_sleeping: assert property (wake_o |-> $past(clock_run_o) == 1'b0 && clock_run_o)
    else $error("wake while not sleeping");
  a_resume_wake: assert property (resume_next_o |-> wake_o)
    else $error("resume without wake");
  a_resume_novec: assert property (resume_next_o |-> !vector_req_o)
    else $error("resume and vector together");
  a_clock_restart: assert property ($rose(clock_run_o) |-> wake_o || core_reset_o)
    else $error("oscillator restarted without wake");
endmodule // wid_top_props

bind wid_top wid_top_props u_props (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .timer_overflow_i(timer_overflow_i),
  .period_match_i(period_match_i), .comparator_change_i(comparator_change_i), .watchdog_timeout_i(watchdog_timeout_i),
  .wake_o(wake_o), .resume_next_o(resume_next_o), .vector_req_o(vector_req_o), .vector_addr_o(vector_addr_o),
  .core_reset_o(core_reset_o), .clock_run_o(clock_run_o));

// ==== wid_top_tb.sv ====
// self-checking bench for wid_top with a reference of the dispatch table
// assumes wid_src_model drives events; axi4-lite master tasks here
module wid_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0] awa = 0, ara = 0, lva;
  logic [31:0] wd = 0, rdv, ie;
  logic [1:0] rsp;
  logic [3:0] ws = 4'hf;
  wire awr, wr, bv, arr, rv, wk, rs, vq, cr, cru, ext;
  wire [1:0] br, rr;
  wire [31:0] rd;
  wire [7:0] va, pins;
  wire [8:0] ev;
  int n_fail = 0, cmp_count = 0, n_wk, n_rs, n_vc, n_cr;
  bit pe, we, ve, re;
  bit [7:0] vt [5] = '{8'h09, 8'h06, 8'h0c, 8'h03, 8'h0f};
  always #2 clk = ~clk;
  wid_src_model src (.sys_clk_i(clk), .ev_o(ev), .pins_o(pins), .ext_o(ext));
  wid_top uut (.sys_clk_i(clk), .srst_i(srst), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(br),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
    .global_int_on_instr_i(ev[6]), .global_int_off_instr_i(ev[7]), .sleep_instr_i(ev[8]),
    .timer_overflow_i(ev[0]), .period_match_i(ev[4]), .comparator_change_i(ev[2]), .watchdog_timeout_i(ev[5]),
    .port6_pins_i(pins), .ext_pin_i(ext), .wake_o(wk), .resume_next_o(rs), .vector_req_o(vq),
    .vector_addr_o(va), .core_reset_o(cr), .clock_run_o(cru));
  always @(posedge clk)
  begin
    n_wk += (wk === 1'b1);
    n_rs += (rs === 1'b1);
    n_vc += (vq === 1'b1);
    n_cr += (cr === 1'b1);
    if (vq === 1'b1) lva = va;
  end
  task results;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task rst;
    @(posedge clk);
    srst <= 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    fork
      begin
        @(posedge clk iff awr);
        awv <= 1'b0;
      end
      begin
        @(posedge clk iff wr);
        wv <= 1'b0;
      end
    join
    @(posedge clk iff bv);
    rsp = br;
    bry <= 1'b0;
  endtask
  task rreg(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    @(posedge clk iff arr);
    arv <= 1'b0;
    @(posedge clk iff rv);
    rdv = rd;
    rsp = rr;
    rry <= 1'b0;
  endtask
  // counters zeroed off the edge, monitor counts on it
  task arm_fire(input int k);
    #1;
    n_wk = 0;
    n_rs = 0;
    n_vc = 0;
    n_cr = 0;
    src.fire(k);
    repeat (8) @(posedge clk);
    #1;
  endtask
  initial
  begin
    #80000;
    n_fail++;
    results;
  end
  initial
  begin
    void'($urandom(32'ha153));
    rst;
    for (int i = 0; i < 5; i++)
    begin
      rreg(i * 4);
      chk("reset value", i == 3 ? 32'h80 : 32'h0, rdv);
      chk("mapped rresp", 2'h0, rsp);
    end
    rreg(8'h14);
    chk("unmapped rresp", 2'h2, rsp);
    wreg(8'h14, 32'h1);
    chk("unmapped bresp", 2'h2, rsp);
    ws <= 4'h0;
    wreg(8'h0c, 32'h0);
    chk("masked bresp", 2'h0, rsp);
    ws <= 4'hf;
    rreg(8'h0c);
    chk("masked write", 32'h80, rdv);
    $display("test registers done");
    for (int k = 0; k < 5; k++)
    begin
      for (int m = 0; m < 16; m++)
      begin
        rst;
        ie = (k == 2 && $urandom_range(1)) ? 32'h80 : 32'h1 << k;
        wreg(8'h00, m[0] ? 32'h6 : 32'h0);
        wreg(8'h04, m[1] ? ie : 32'h0);
        wreg(8'h0c, 32'h0);
        src.fire(m[2] ? 6 : 7);
        if (m[3]) src.fire(8);
        arm_fire(k);
        pe = m[1] && (!m[3] || k == 1 || k == 2);
        we = m[3] && m[0] && (k == 1 || k == 2);
        ve = pe && m[2] && (!m[3] || we);
        re = we && !ve;
        chk("events", {8'(n_wk), 8'(n_rs), 8'(n_vc), 8'(n_cr)}, {8'(we), 8'(re), 8'(ve), 8'h0});
        if (ve) chk("vector addr", vt[k], lva);
        chk("clock run", !m[3] || we, cru);
        rreg(8'h08);
        chk("pending", 32'(pe) << k, rdv);
        rreg(8'h0c);
        chk("watchdog enable", 32'(we) << 7, rdv);
        rreg(8'h10);
        chk("status", {m[3] && !we, m[2]}, rdv);
        wreg(8'h08, 32'h1f);
        chk("mapped bresp", 2'h0, rsp);
        rreg(8'h08);
        chk("pending cleared", 32'h0, rdv);
      end
      $display("test source %0d done", k);
    end
    for (int i = 0; i < 4; i++)
    begin
      rst;
      wreg(8'h0c, i[1] ? 32'h80 : 32'h0);
      if (i[0]) src.fire(8);
      arm_fire(5);
      chk("watchdog", {8'(n_cr), 8'(n_rs), 8'(n_vc), 8'(n_wk)}, {8'(i[1]), 16'h0, 8'(i[0] && i[1])});
      chk("watchdog run", !i[0] || i[1], cru);
      if (i[1]) chk("reset addr", 8'h00, va);
    end
    $display("test watchdog done");
    results;
  end
endmodule // wid_top_tb
